// >>> common/scsd_params.svh
// Constants for the system clock source and divider block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SCSD_PARAMS_SVH
`define SCSD_PARAMS_SVH

// ********************************
// Register address width and byte offsets
// ********************************
`define SCSD_ADDR_W            12
`define SCSD_STATUS_ADDR       12'h050
`define SCSD_CFG_ADDR          12'h060
`define SCSD_CFX_ADDR          12'h070
`define SCSD_PCLK_EN_ADDR      12'h100
`define SCSD_DSLP_ADDR         12'h144

// ********************************
// Reset values
// ********************************
`define SCSD_CFG_RESET         32'h0780_2811
`define SCSD_CFX_RESET         32'h0780_2810
`define SCSD_DSLP_RESET        32'h0780_0010
`define SCSD_PCLK_EN_RESET     8'h00

// ********************************
// Field positions
// ********************************
`define SCSD_CFG_MAIN_DIS      0
`define SCSD_CFG_SRC_LSB       4
`define SCSD_CFG_SRC_MSB       5
`define SCSD_CFG_SKIP          11
`define SCSD_CFG_PWRDN         13
`define SCSD_CFG_DIV_LSB       23
`define SCSD_CFG_DIV_MSB       26
`define SCSD_CFX_OVR           31
`define SCSD_CFX_FINE_EN       30
`define SCSD_CFX_DIV_MSB       28
`define SCSD_CFX_DIV_LSB       23
`define SCSD_CFX_FINE_BIT      22
`define SCSD_CFX_PWRDN         13
`define SCSD_CFX_SKIP          11
`define SCSD_CFX_SRC_MSB       6
`define SCSD_CFX_SRC_LSB       4

// ********************************
// Dividers, timing and peripheral clock count
// ********************************
`define SCSD_PREC_QUARTER      8'd4
`define SCSD_PLL_PREDIV        8'd2
`define SCSD_ADC_DIV           8'd25
`define SCSD_PLL_LOCK_CYCLES   9216
`define SCSD_PCLK_N            8

`endif

// >>> common/scsd_pkg.sv
// Types for the system clock source and divider block.
// Assumes the constants header is on the include path.
`include "scsd_params.svh"

package scsd_pkg;

  // Oscillator source select encodings
  typedef enum logic [2:0] {
    SCSD_SRC_MAIN   = 3'h0,
    SCSD_SRC_PREC   = 3'h1,
    SCSD_SRC_QUART  = 3'h2,
    SCSD_SRC_SLOW   = 3'h3
  } scsd_src_t;

  // PLL lock tracking
  typedef enum logic [1:0] {
    SCSD_PLL_OFF     = 2'h0,
    SCSD_PLL_LOCKING = 2'h1,
    SCSD_PLL_READY   = 2'h2
  } scsd_pll_st_t;

endpackage

// >>> logic/scsd_tick_div.sv
// Divides a stream of one-cycle tick pulses by a run-time divisor.
// Assumes in_tick is synchronous to clk and divisor is at least one.
`timescale 1ns/100ps

module scsd_tick_div #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_tick,
  input  wire logic [WIDTH-1:0] divisor,
  output logic                  out_tick
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic             out_reg;
  logic             out_next;

  always_comb begin
    cnt_next = cnt_reg;
    out_next = 1'b0;
    if (in_tick) begin
      if (cnt_reg >= divisor - WIDTH'(1)) begin
        cnt_next = '0;
        out_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign out_tick = out_reg;

endmodule

// >>> logic/scsd_clk_gen.sv
// Builds the system clock level from source ticks and a divisor.
// Assumes divisor is steady except where the owner reloads it at wrap.
`timescale 1ns/100ps

module scsd_clk_gen (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       in_tick,
  input  wire logic [7:0] divisor,
  output logic            clk_level,
  output logic            period_end
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       lvl_reg;
  logic       lvl_next;
  logic [7:0] half;

  // ********************************
  // Period counter
  // ********************************
  // High for the first half of the period; divisor is compared on every tick,
  // so the owner must only change it as the count wraps
  always_comb begin
    half     = (divisor + 8'h01) >> 1;
    cnt_next = cnt_reg;
    lvl_next = lvl_reg;
    if (in_tick) begin
      if (cnt_reg >= divisor - 8'h01) begin
        cnt_next = 8'h00;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
      if (divisor == 8'h01) begin
        lvl_next = ~lvl_reg;
      end else begin
        lvl_next = (cnt_next < half);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= 8'h00;
      lvl_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      lvl_reg <= lvl_next;
    end
  end

  assign clk_level  = lvl_reg;
  assign period_end = in_tick && (cnt_reg >= divisor - 8'h01);

endmodule

// >>> logic/scsd_top.sv
// System clock source selection and division with an AHB-Lite register slave.
// Assumes oscillator and PLL inputs are one-cycle ticks synchronous to CLOCK.
//
// Summary of operation
// R1: From reset the system clock runs from the precision internal oscillator.
// R2: Software enables the main oscillator and waits before selecting it.
// R3: With PLL skipped, source select picks main, precision, quarter or slow.
// R4: Only main or precision oscillator may be the PLL reference.
// R5: A quarter-rate precision oscillator source is provided.
// R6: Override bit lets the extended register govern in place of the first.
// R7: Software writes the first register before the extended one.
// R8: ADC clock is the PLL output divided down once the PLL is locked.
// R9: Software keeps system clock fast enough for ADC and USB.
// R10: Each peripheral clock comes from system clock with its own enable.
// R11: Four-bit divider divides by encoding plus one, reset value divide-by-16.
// R12: Without fine enable, PLL output is halved before the system divider.
// R13: Extended divider is six bits, up to divide-by-64.
// R14: Fine enable appends the fine bit below the extended divider.
// R15: Without fine enable the fine bit is ignored.
// R16: Fine enable and fine bit act only while PLL skip is clear, outside deep sleep.
// R17: In deep sleep a separate register sets source and divider.
// R18: Main oscillator is the only USB PLL reference.
// R19: Fine enable skips the PLL halving predivider.
// R20: Until PLL lock elapses the selected oscillator keeps clocking.
// R21: Source and divider changes wait for period end unless the PLL in use loses lock.
`timescale 1ns/100ps
`include "scsd_params.svh"

module scsd_top #(
  parameter int PLL_LOCK_CYCLES = `SCSD_PLL_LOCK_CYCLES
) (
  input  wire logic                      CLOCK,
  input  wire logic                      SRST,
  input  wire logic                      HSEL,
  input  wire logic [31:0]               HADDR,
  input  wire logic [1:0]                HTRANS,
  input  wire logic                      HWRITE,
  input  wire logic [2:0]                HSIZE,
  input  wire logic [31:0]               HWDATA,
  input  wire logic                      HREADY,
  output logic                           HREADYOUT,
  output logic [31:0]                    HRDATA,
  output logic                           HRESP,
  input  wire logic                      MAIN_OSC_TICK,
  input  wire logic                      PRECISION_OSC_TICK,
  input  wire logic                      SLOW_OSC_TICK,
  input  wire logic                      PLL_TICK,
  input  wire logic                      DEEP_SLEEP,
  output logic                           MAIN_OSC_ENABLE,
  output logic                           PLL_POWER,
  output logic                           PLL_REF_MAIN,
  output logic                           SYSTEM_CLOCK,
  output logic                           ADC_CLOCK_TICK,
  output logic [`SCSD_PCLK_N-1:0]        PERIPH_CLOCK
);

  // ********************************
  // Bus slave state
  // ********************************
  logic                     dp_wr_reg;
  logic                     dp_wr_next;
  logic                     dp_rd_reg;
  logic                     dp_rd_next;
  logic [`SCSD_ADDR_W-1:0]  dp_addr_reg;
  logic [`SCSD_ADDR_W-1:0]  dp_addr_next;
  logic [31:0]              rdata_reg;
  logic [31:0]              rdata_next;
  logic                     rd_done_reg;
  logic                     rd_done_next;
  logic [31:0]              cfg_reg;
  logic [31:0]              cfg_next;
  logic [31:0]              cfx_reg;
  logic [31:0]              cfx_next;
  logic [31:0]              dslp_reg;
  logic [31:0]              dslp_next;
  logic [`SCSD_PCLK_N-1:0]  pclk_en_reg;
  logic [`SCSD_PCLK_N-1:0]  pclk_en_next;
  logic [31:0]              status_word;
  logic                     take;

  // ********************************
  // Clock path state
  // ********************************
  scsd_pkg::scsd_pll_st_t   pll_st_reg;
  scsd_pkg::scsd_pll_st_t   pll_st_next;
  logic [15:0]              lock_cnt_reg;
  logic [15:0]              lock_cnt_next;
  logic [2:0]               lock_src_reg;
  logic [2:0]               lock_src_next;
  logic [2:0]               act_src_reg;
  logic [2:0]               act_src_next;
  logic                     act_pll_reg;
  logic                     act_pll_next;
  logic                     act_fine_reg;
  logic                     act_fine_next;
  logic [7:0]               act_div_reg;
  logic [7:0]               act_div_next;
  logic [`SCSD_PCLK_N-1:0]  pclk_reg;
  logic [`SCSD_PCLK_N-1:0]  pclk_next;

  logic                     want_skip;
  logic                     want_pwrdn;
  logic                     want_fine;
  logic [2:0]               want_src;
  logic [7:0]               want_div;
  logic                     ref_ok;
  logic                     quarter_tick;
  logic                     pll_half_tick;
  logic                     osc_tick;
  logic                     src_tick;
  logic                     sys_level;
  logic                     period_end;

  // ********************************
  // AHB-Lite slave
  // ********************************
  // Reads take one wait state so read data always comes from a flop and
  // reflects a write in the preceding data phase
  assign take = HSEL && HREADY && HTRANS[1];

  always_comb begin
    dp_wr_next   = take && HWRITE;
    dp_rd_next   = take && !HWRITE;
    dp_addr_next = take ? HADDR[`SCSD_ADDR_W-1:0] : dp_addr_reg;
    rd_done_next = dp_rd_reg && !rd_done_reg;
    rdata_next   = rdata_reg;
    if (dp_rd_reg && !rd_done_reg) begin
      case (dp_addr_reg)
        `SCSD_STATUS_ADDR:  rdata_next = status_word;
        `SCSD_CFG_ADDR:     rdata_next = cfg_reg;
        `SCSD_CFX_ADDR:     rdata_next = cfx_reg;
        `SCSD_DSLP_ADDR:    rdata_next = dslp_reg;
        `SCSD_PCLK_EN_ADDR: rdata_next = {24'h000000, pclk_en_reg};
        default:            rdata_next = 32'h0000_0000;
      endcase
    end
    if (dp_rd_reg && !rd_done_reg) begin
      dp_rd_next = 1'b1;
      dp_wr_next = 1'b0;
    end
  end

  always_comb begin
    cfg_next     = cfg_reg;
    cfx_next     = cfx_reg;
    dslp_next    = dslp_reg;
    pclk_en_next = pclk_en_reg;
    if (dp_wr_reg) begin
      case (dp_addr_reg)
        `SCSD_CFG_ADDR:     cfg_next     = HWDATA;
        `SCSD_CFX_ADDR:     cfx_next     = HWDATA;
        `SCSD_DSLP_ADDR:    dslp_next    = HWDATA;
        `SCSD_PCLK_EN_ADDR: pclk_en_next = HWDATA[`SCSD_PCLK_N-1:0];
        default:            cfg_next     = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      dp_wr_reg   <= 1'b0;
      dp_rd_reg   <= 1'b0;
      dp_addr_reg <= '0;
      rdata_reg   <= 32'h0000_0000;
      rd_done_reg <= 1'b0;
      cfg_reg     <= `SCSD_CFG_RESET;   // R1 R11
      cfx_reg     <= `SCSD_CFX_RESET;
      dslp_reg    <= `SCSD_DSLP_RESET;
      pclk_en_reg <= `SCSD_PCLK_EN_RESET;
    end else begin
      dp_wr_reg   <= dp_wr_next;
      dp_rd_reg   <= dp_rd_next && !rd_done_next ? 1'b1 : dp_rd_next && !dp_rd_reg;
      dp_addr_reg <= dp_addr_next;
      rdata_reg   <= rdata_next;
      rd_done_reg <= rd_done_next;
      cfg_reg     <= cfg_next;
      cfx_reg     <= cfx_next;
      dslp_reg    <= dslp_next;
      pclk_en_reg <= pclk_en_next;
    end
  end

  assign HREADYOUT = !(dp_rd_reg && !rd_done_reg);
  assign HRDATA    = rdata_reg;
  assign HRESP     = 1'b0;

  assign status_word = {16'h0000, act_div_reg, 1'b0, act_src_reg, 1'b0, DEEP_SLEEP,
                        act_pll_reg, (pll_st_reg == scsd_pkg::SCSD_PLL_READY)};

  // ********************************
  // Effective configuration
  // ********************************
  always_comb begin
    if (cfx_reg[`SCSD_CFX_OVR]) begin                                        // R6
      want_skip  = cfx_reg[`SCSD_CFX_SKIP];
      want_pwrdn = cfx_reg[`SCSD_CFX_PWRDN];
      want_src   = cfx_reg[`SCSD_CFX_SRC_MSB:`SCSD_CFX_SRC_LSB];
      want_fine  = cfx_reg[`SCSD_CFX_FINE_EN] && !cfx_reg[`SCSD_CFX_SKIP];   // R16
      if (want_fine) begin
        want_div = {1'b0, cfx_reg[`SCSD_CFX_DIV_MSB:`SCSD_CFX_DIV_LSB],
                    cfx_reg[`SCSD_CFX_FINE_BIT]} + 8'h01;                    // R14
      end else begin
        want_div = {2'b00, cfx_reg[`SCSD_CFX_DIV_MSB:`SCSD_CFX_DIV_LSB]}
                   + 8'h01;                                                   // R13 R15
      end
    end else begin
      want_skip  = cfg_reg[`SCSD_CFG_SKIP];
      want_pwrdn = cfg_reg[`SCSD_CFG_PWRDN];
      want_src   = {1'b0, cfg_reg[`SCSD_CFG_SRC_MSB:`SCSD_CFG_SRC_LSB]};
      want_fine  = 1'b0;
      want_div   = {4'h0, cfg_reg[`SCSD_CFG_DIV_MSB:`SCSD_CFG_DIV_LSB]} + 8'h01; // R11
    end
    if (DEEP_SLEEP) begin                                                     // R17
      want_skip = 1'b1;
      want_fine = 1'b0;
      want_src  = dslp_reg[`SCSD_CFX_SRC_MSB:`SCSD_CFX_SRC_LSB];
      want_div  = {2'b00, dslp_reg[`SCSD_CFX_DIV_MSB:`SCSD_CFX_DIV_LSB]} + 8'h01;
    end
  end

  // Quarter and slow sources can never lock the PLL
  assign ref_ok = (want_src == scsd_pkg::SCSD_SRC_MAIN) ||
                  (want_src == scsd_pkg::SCSD_SRC_PREC);                     // R4

  // ********************************
  // PLL lock tracking
  // ********************************
  always_comb begin
    pll_st_next   = pll_st_reg;
    lock_cnt_next = lock_cnt_reg;
    lock_src_next = want_src;
    case (pll_st_reg)
      scsd_pkg::SCSD_PLL_OFF: begin
        if (!want_pwrdn && ref_ok) begin
          pll_st_next   = scsd_pkg::SCSD_PLL_LOCKING;
          lock_cnt_next = 16'(PLL_LOCK_CYCLES - 1);
        end
      end
      scsd_pkg::SCSD_PLL_LOCKING: begin
        if (lock_cnt_reg == 16'h0000) begin
          pll_st_next = scsd_pkg::SCSD_PLL_READY;                             // R20
        end else begin
          lock_cnt_next = lock_cnt_reg - 16'h0001;
        end
      end
      scsd_pkg::SCSD_PLL_READY: begin
        pll_st_next = scsd_pkg::SCSD_PLL_READY;
      end
      default: begin
        pll_st_next = scsd_pkg::SCSD_PLL_OFF;
      end
    endcase
    if (want_pwrdn || !ref_ok) begin
      pll_st_next = scsd_pkg::SCSD_PLL_OFF;
    end else if (pll_st_reg != scsd_pkg::SCSD_PLL_OFF && lock_src_reg != want_src) begin
      pll_st_next   = scsd_pkg::SCSD_PLL_LOCKING;                             // R20
      lock_cnt_next = 16'(PLL_LOCK_CYCLES - 1);
    end
  end

  // ********************************
  // Source selection at period end
  // ********************************
  // Config is adopted as the running period completes, or at once if the PLL in use loses lock
  always_comb begin
    act_src_next  = act_src_reg;
    act_pll_next  = act_pll_reg;
    act_fine_next = act_fine_reg;
    act_div_next  = act_div_reg;
    if (period_end || (act_pll_reg && pll_st_reg != scsd_pkg::SCSD_PLL_READY)) begin // R21
      act_src_next  = want_src;
      act_pll_next  = !want_skip && (pll_st_reg == scsd_pkg::SCSD_PLL_READY);         // R20
      act_fine_next = want_fine;
      act_div_next  = want_div;
    end
    pclk_next = {`SCSD_PCLK_N{sys_level}} & pclk_en_reg;                               // R10
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pll_st_reg   <= scsd_pkg::SCSD_PLL_OFF;
      lock_cnt_reg <= 16'h0000;
      lock_src_reg <= scsd_pkg::SCSD_SRC_PREC;
      act_src_reg  <= scsd_pkg::SCSD_SRC_PREC;                                         // R1
      act_pll_reg  <= 1'b0;
      act_fine_reg <= 1'b0;
      act_div_reg  <= 8'h10;
      pclk_reg     <= '0;
    end else begin
      pll_st_reg   <= pll_st_next;
      lock_cnt_reg <= lock_cnt_next;
      lock_src_reg <= lock_src_next;
      act_src_reg  <= act_src_next;
      act_pll_reg  <= act_pll_next;
      act_fine_reg <= act_fine_next;
      act_div_reg  <= act_div_next;
      pclk_reg     <= pclk_next;
    end
  end

  always_comb begin
    case (act_src_reg)
      scsd_pkg::SCSD_SRC_MAIN:  osc_tick = MAIN_OSC_TICK;                              // R3
      scsd_pkg::SCSD_SRC_PREC:  osc_tick = PRECISION_OSC_TICK;
      scsd_pkg::SCSD_SRC_QUART: osc_tick = quarter_tick;
      scsd_pkg::SCSD_SRC_SLOW:  osc_tick = SLOW_OSC_TICK;
      default:                  osc_tick = PRECISION_OSC_TICK;
    endcase
    if (act_pll_reg) begin
      src_tick = act_fine_reg ? PLL_TICK : pll_half_tick;                              // R12 R19
    end else begin
      src_tick = osc_tick;
    end
  end

  // ********************************
  // Dividers
  // ********************************
  scsd_tick_div #(.WIDTH(8)) u_quarter (                                               // R5
    .clk      (CLOCK),
    .srst     (SRST),
    .in_tick  (PRECISION_OSC_TICK),
    .divisor  (`SCSD_PREC_QUARTER),
    .out_tick (quarter_tick)
  );

  scsd_tick_div #(.WIDTH(8)) u_pll_half (                                              // R12
    .clk      (CLOCK),
    .srst     (SRST),
    .in_tick  (PLL_TICK),
    .divisor  (`SCSD_PLL_PREDIV),
    .out_tick (pll_half_tick)
  );

  scsd_tick_div #(.WIDTH(8)) u_adc (                                                   // R8
    .clk      (CLOCK),
    .srst     (SRST),
    .in_tick  (PLL_TICK && (pll_st_reg == scsd_pkg::SCSD_PLL_READY)),
    .divisor  (`SCSD_ADC_DIV),
    .out_tick (ADC_CLOCK_TICK)
  );

  scsd_clk_gen u_gen (                                                                 // R21
    .clk        (CLOCK),
    .srst       (SRST),
    .in_tick    (src_tick),
    .divisor    (act_div_reg),
    .clk_level  (sys_level),
    .period_end (period_end)
  );

  // ********************************
  // Outputs
  // ********************************
  assign SYSTEM_CLOCK    = sys_level;
  assign PERIPH_CLOCK    = pclk_reg;
  assign MAIN_OSC_ENABLE = !cfg_reg[`SCSD_CFG_MAIN_DIS];
  assign PLL_POWER       = !want_pwrdn && ref_ok;
  assign PLL_REF_MAIN    = (lock_src_reg == scsd_pkg::SCSD_SRC_MAIN);                  // R4

endmodule

// >>> sim/scsd_top_props.sv
// Port checker for the system clock block.
// Bound to scsd_top; PLL ticks may come every cycle.
`timescale 1ns/100ps

module scsd_top_props #(
  parameter int PLL_LOCK_CYCLES = 8
) (
  input wire logic       CLOCK,
  input wire logic       SRST,
  input wire logic       HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic       HWRITE,
  input wire logic       HREADY,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  input wire logic       PLL_POWER,
  input wire logic       SYSTEM_CLOCK,
  input wire logic       ADC_CLOCK_TICK,
  input wire logic [7:0] PERIPH_CLOCK
);
  logic       take;
  logic [7:0] gap_reg;
  logic [7:0] gap_next;

  assign take = HSEL && HREADY && HTRANS[1];
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  // ********
  // Cycles since last ADC tick, saturating
  // ********
  always_comb begin
    gap_next = (gap_reg == 8'hff) ? gap_reg : gap_reg + 8'h01;
    if (ADC_CLOCK_TICK || SRST) begin
      gap_next = SRST ? 8'hff : 8'h00;
    end
  end

  always_ff @(posedge CLOCK) begin
    gap_reg <= gap_next;
  end

  a_bus_okay: assert property (HRESP == 1'b0) else $error("bus response not okay");
  a_write_nowait: assert property (take && HWRITE |=> HREADYOUT) else $error("write stalled");
  a_read_onewait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait wrong");
  a_stall_cause: assert property (!HREADYOUT |-> $past(take && !HWRITE))
    else $error("stall without read");
  a_reset_quiet: assert property ($past(SRST) |-> !SYSTEM_CLOCK && !ADC_CLOCK_TICK
    && PERIPH_CLOCK == 8'h00 && !PLL_POWER) else $error("outputs busy after reset");
  a_adc_from_pll: assert property (ADC_CLOCK_TICK |-> $past(PLL_POWER)
    || $past(PLL_POWER, 2) || $past(PLL_POWER, 3)) else $error("ADC tick without PLL");
  a_adc_spacing: assert property (ADC_CLOCK_TICK |-> gap_reg >= 8'd24)
    else $error("ADC ticks too close");
  a_periph_gated: assert property ((PERIPH_CLOCK & ~{8{$past(SYSTEM_CLOCK)}}) == 8'h00)
    else $error("peripheral clock not from system clock");

  c_adc: cover property (ADC_CLOCK_TICK);
  c_rise: cover property ($rose(SYSTEM_CLOCK));
  c_periph: cover property (PERIPH_CLOCK != 8'h00);
endmodule

bind scsd_top scsd_top_props #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) u_props (
  .CLOCK(CLOCK), .SRST(SRST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PLL_POWER(PLL_POWER),
  .SYSTEM_CLOCK(SYSTEM_CLOCK), .ADC_CLOCK_TICK(ADC_CLOCK_TICK), .PERIPH_CLOCK(PERIPH_CLOCK)
);

// >>> sim/system_clock_source_divider_tb.sv
// Bench for scsd_top: AHB-Lite register access and clock period checks.
// Assumes one bus master; oscillators are modelled as tick counters.
`timescale 1ns/100ps
`include "scsd_params.svh"

module system_clock_source_divider_tb;
  logic        CLOCK = 1'b0;
  logic        SRST = 1'b1;
  logic        HSEL = 1'b0, HWRITE = 1'b0, DEEP_SLEEP = 1'b0, prev;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
  logic [1:0]  HTRANS = 2'h0;
  logic        HREADY, HREADYOUT, HRESP, MAIN_OSC_ENABLE, PLL_POWER, PLL_REF_MAIN;
  logic        MAIN_OSC_TICK = 1'b0, PRECISION_OSC_TICK = 1'b0, SLOW_OSC_TICK = 1'b0;
  logic        SYSTEM_CLOCK, ADC_CLOCK_TICK;
  logic [7:0]  PERIPH_CLOCK;
  int          n_fail = 0, n_tests = 0, cyc = 0, c;
  int          per[4] = '{3, 2, 8, 5};

  // Bus ready is the one slave's ready
  assign HREADY = HREADYOUT;
  always #50 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    MAIN_OSC_TICK <= (cyc % 3 == 0);
    PRECISION_OSC_TICK <= (cyc % 2 == 0);
    SLOW_OSC_TICK <= (cyc % 5 == 0);
  end

  scsd_top #(.PLL_LOCK_CYCLES(8)) uut (
    .CLOCK(CLOCK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .MAIN_OSC_TICK(MAIN_OSC_TICK),
    .PRECISION_OSC_TICK(PRECISION_OSC_TICK), .SLOW_OSC_TICK(SLOW_OSC_TICK),
    .PLL_TICK(1'b1), .DEEP_SLEEP(DEEP_SLEEP), .MAIN_OSC_ENABLE(MAIN_OSC_ENABLE),
    .PLL_POWER(PLL_POWER), .PLL_REF_MAIN(PLL_REF_MAIN), .SYSTEM_CLOCK(SYSTEM_CLOCK),
    .ADC_CLOCK_TICK(ADC_CLOCK_TICK), .PERIPH_CLOCK(PERIPH_CLOCK)
  );

  // ********
  // Tasks
  // ********
  task tally_and_finish;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    HSEL <= 1'b1;
    HADDR <= {20'h0, a};
    HWRITE <= wr;
    HTRANS <= 2'h2;
    do begin @(posedge CLOCK); k++; end while (HREADY !== 1'b1 && k < 50);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do begin @(posedge CLOCK); k++; end while (HREADY !== 1'b1 && k < 100);
    rd = HRDATA;
    if (k >= 100) begin n_fail++; tally_and_finish(); end
  endtask

  // Level seen before each edge settles; counts cycles spent waiting
  task lvl(input logic v);
    int k;
    k = 0;
    while (SYSTEM_CLOCK !== v && k < 2000) begin @(posedge CLOCK); k++; c++; end
    if (k >= 2000) begin n_fail++; tally_and_finish(); end
  endtask

  // Third period is past any change taken at a period end
  task period(input int exp);
    lvl(1'b0);
    lvl(1'b1);
    repeat (3) begin c = 0; lvl(1'b0); lvl(1'b1); end
    chk(c, exp);
  endtask

  function logic [31:0] cfg(input logic [1:0] src, input logic [3:0] dv);
    return {5'h0, dv, 9'h0, 1'b1, 1'b0, 1'b1, 5'h0, src, 4'h0};
  endfunction

  function logic [31:0] cfx(input logic fe, input logic [5:0] ext, input logic fb,
                            input logic pd, input logic skip, input logic [2:0] src);
    return {1'b1, fe, 1'b0, ext, fb, 8'h0, pd, 1'b0, skip, 4'h0, src, 4'h0};
  endfunction

  // ********
  // Tests
  // ********
  initial begin
    repeat (90000) @(posedge CLOCK);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge CLOCK);
    SRST <= 1'b0;
    @(posedge CLOCK);
    bus(0, 12'h060, 0); chk(rd, `SCSD_CFG_RESET);
    bus(0, 12'h070, 0); chk(rd, `SCSD_CFX_RESET);
    bus(0, 12'h144, 0); chk(rd, `SCSD_DSLP_RESET);
    bus(1, 12'h200, 32'hffff_ffff);
    bus(0, 12'h200, 0); chk(rd, 32'h0);
    chk(MAIN_OSC_ENABLE, 1'b0);
    period(32);
    $display("test reset done");
    bus(1, 12'h060, cfg(2'h1, 4'h2));
    @(posedge CLOCK);
    chk(MAIN_OSC_ENABLE, 1'b1);
    for (int i = 0; i < 4; i++) begin
      bus(1, 12'h060, cfg(i[1:0], 4'h2));
      period(3 * per[i]);
    end
    $display("test sources done");
    bus(0, 12'h050, 0);
    bus(1, 12'h070, cfx(1'b0, 6'h3f, 1'b0, 1'b1, 1'b1, 3'h1));
    period(128);
    bus(1, 12'h070, cfx(1'b0, 6'h3f, 1'b0, 1'b1, 1'b1, 3'h1) & 32'h7fff_ffff);
    period(15);
    $display("test override done");
    bus(1, 12'h070, cfx(1'b0, 6'h03, 1'b0, 1'b0, 1'b0, 3'h1));
    bus(0, 12'h050, 0); chk(rd[1:0], 2'h0);
    period(8);
    bus(0, 12'h050, 0); chk(rd[1:0], 2'h3);
    c = 0;
    repeat (250) begin @(posedge CLOCK); c += (ADC_CLOCK_TICK === 1'b1); end
    chk(c, 10);
    bus(1, 12'h070, cfx(1'b0, 6'h03, 1'b0, 1'b0, 1'b0, 3'h2));
    @(posedge CLOCK);
    chk(PLL_POWER, 1'b0);
    bus(1, 12'h070, cfx(1'b0, 6'h03, 1'b0, 1'b0, 1'b0, 3'h0));
    repeat (2) @(posedge CLOCK);
    chk({PLL_POWER, PLL_REF_MAIN}, 2'h3);
    $display("test pll done");
    bus(1, 12'h070, cfx(1'b1, 6'h03, 1'b1, 1'b0, 1'b0, 3'h0));
    period(8);
    bus(1, 12'h070, cfx(1'b1, 6'h03, 1'b0, 1'b0, 1'b0, 3'h0));
    period(7);
    bus(1, 12'h070, cfx(1'b0, 6'h03, 1'b1, 1'b0, 1'b0, 3'h0));
    period(8);
    bus(1, 12'h070, cfx(1'b1, 6'h03, 1'b1, 1'b0, 1'b1, 3'h0));
    period(12);
    $display("test fine done");
    bus(1, 12'h144, {3'h0, 6'h03, 16'h0, 3'h1, 4'h0});
    DEEP_SLEEP <= 1'b1;
    period(8);
    bus(0, 12'h050, 0); chk(rd[2], 1'b1);
    DEEP_SLEEP <= 1'b0;
    period(12);
    $display("test sleep done");
    bus(1, 12'h100, 32'h0000_0005);
    bus(0, 12'h100, 0); chk(rd, 32'h5);
    prev = SYSTEM_CLOCK;
    repeat (40) begin
      @(posedge CLOCK);
      chk(PERIPH_CLOCK, {8{prev}} & 8'h05);
      prev = SYSTEM_CLOCK;
    end
    $display("test periph done");
    tally_and_finish();
  end
endmodule
